// ===== design/flash_key_margin_consts.svh
/*
  constants for the key verify and margin command sequencer.
  assumes inclusion by bare name from the design files only.
*/
`ifndef FLASH_KEY_MARGIN_CONSTS_SVH
`define FLASH_KEY_MARGIN_CONSTS_SVH

// command codes, taken from buffer word at index 0
`define CMD_KEY_VERIFY      8'h0C
`define CMD_USER_MARGIN     8'h0D
`define CMD_FIELD_MARGIN    8'h0E

// parameter index values
`define IDX_HEADER          3'h0
`define IDX_SETTING         3'h1
`define IDX_KEY_LAST        3'h4
`define KEY_FIRST_IDX       3'h1

// backdoor enable field value that allows key access
`define BACKDOOR_ENABLED    2'h2

// stored comparison key base, global address
`define KEY_BASE_ADDR       18'h3FF00

// block select values of global address [17:16]
`define BLOCK_PFLASH        2'h0
`define BLOCK_EEPROM        2'h1

// margin settings
`define MARGIN_NORMAL       3'h0
`define MARGIN_USER_ERASED  3'h1
`define MARGIN_USER_PROG    3'h2
`define MARGIN_FIELD_ERASED 3'h3
`define MARGIN_FIELD_PROG   3'h4
`define MARGIN_USER_MAX     16'h0002
`define MARGIN_FIELD_MAX    16'h0004

// latency of the key read and compare step
`define KEY_READ_CYCLES     3'h4

`endif

// ===== design/flash_key_margin_pkg.sv
/*
  types for the key verify and margin command sequencer.
  assumes no surroundings; used by the sequencer and margin select design files.
*/
package flash_key_margin_pkg;

  typedef enum logic [3:0] {
    SEQ_IDLE   = 4'b0001,
    SEQ_DECODE = 4'b0010,
    SEQ_KEYCMP = 4'b0100,
    SEQ_DONE   = 4'b1000
  } seq_state_t;

  typedef logic [2:0] margin_level_t;

endpackage

// ===== design/key_compare.sv
/*
  compares four supplied keys against four stored keys, one word
  per cycle over a simple read port into the configuration field.
  assumes the read port answers combinationally in the same cycle.
*/
`timescale 1ns/1ps
`include "flash_key_margin_consts.svh"

module key_compare #(
  parameter int KEY_W = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic [KEY_W-1:0] suppliedKey [4],
  output logic      [17:0]      keyReadAddr,
  input  wire logic [KEY_W-1:0] keyReadData,
  output logic                  cmpDone,
  output logic                  cmpMatch
);

  logic [2:0] wordCnt_q;
  logic       busy_q;
  logic       allEq_q;
  logic       wordEq;

  // key n read one word past key n-1, key 0 at the base
  assign keyReadAddr = `KEY_BASE_ADDR + {16'h0, wordCnt_q[1:0]};
  assign wordEq      = (keyReadData == suppliedKey[wordCnt_q[1:0]]);

  // walk the four words, keep a running match
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wordCnt_q <= 3'h0;
      busy_q    <= 1'b0;
      allEq_q   <= 1'b1;
      cmpDone   <= 1'b0;
      cmpMatch  <= 1'b0;
    end else begin
      cmpDone <= 1'b0;
      if (start && !busy_q) begin
        busy_q    <= 1'b1;
        wordCnt_q <= 3'h0;
        allEq_q   <= 1'b1;
      end else if (busy_q) begin
        allEq_q   <= allEq_q & wordEq;
        wordCnt_q <= wordCnt_q + 3'h1;
        if (wordCnt_q == `KEY_READ_CYCLES - 3'h1) begin
          busy_q   <= 1'b0;
          cmpDone  <= 1'b1;
          cmpMatch <= allEq_q & wordEq;
        end
      end
    end
  end

endmodule

// ===== design/margin_select.sv
/*
  holds user and field margin levels for both arrays and derives the
  level each array's reads use.
  assumes writes come only from the command sequencer.
*/
`timescale 1ns/1ps
`include "flash_key_margin_consts.svh"

module margin_select
  import flash_key_margin_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          wrEn,
  input  wire logic          wrEeprom,
  input  wire margin_level_t wrLevel,
  output margin_level_t      pflashReadMargin,
  output margin_level_t      eepromReadMargin
);

  margin_level_t pflashLvl_q;
  margin_level_t eepromLvl_q;

  // a p-flash target sets both arrays, eeprom target only eeprom
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pflashLvl_q <= `MARGIN_NORMAL;
      eepromLvl_q <= `MARGIN_NORMAL;
    end else if (wrEn) begin
      eepromLvl_q <= wrLevel;
      if (!wrEeprom) begin
        pflashLvl_q <= wrLevel;
      end
    end
  end

  assign pflashReadMargin = pflashLvl_q;
  assign eepromReadMargin = eepromLvl_q;

endmodule

// ===== design/flash_key_margin_commands.sv
/*
  command sequencer for backdoor key verify, user margin and field
  margin commands of the flash controller.
  assumes software loads the parameter buffer through bufWrEn while
  cmdCompleteFlag is high and launches by a one-cycle clear strobe;
  other commands are handled elsewhere and ignored here.
*/
`timescale 1ns/1ps
`include "flash_key_margin_consts.svh"

module flash_key_margin_commands
  import flash_key_margin_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              bufWrEn,
  input  wire logic [2:0]        bufWrIdx,
  input  wire logic [DATA_W-1:0] bufWrData,
  input  wire logic [2:0]        paramIndex,
  input  wire logic              cmdLaunch,
  input  wire logic              accessErrClear,
  input  wire logic [1:0]        backdoorEnableField,
  input  wire logic              specialMode,
  input  wire logic              userMarginAllowed,
  input  wire logic              securedAtReset,
  output logic      [17:0]       keyReadAddr,
  input  wire logic [DATA_W-1:0] keyReadData,
  output logic                   cmdCompleteFlag,
  output logic                   accessErrorFlag,
  output logic                   protectionViolationFlag,
  output logic                   verifyFailHi,
  output logic                   verifyFailLo,
  output logic                   secured,
  output margin_level_t          pflashReadMargin,
  output margin_level_t          eepromReadMargin
);

  // parameter buffer, one word per index
  logic [DATA_W-1:0] paramBuf_q [8];
  logic [DATA_W-1:0] keyWords   [4];

  seq_state_t state_q;
  seq_state_t state_d;
  logic       cmd_complete_flag_q;
  logic       access_error_flag_q;
  logic       secured_q;
  logic       keyLock_q;
  logic       strapTaken_q;
  logic [2:0] idx_q;

  // decode of the header word and the setting word
  wire [7:0]  cmdCode   = paramBuf_q[`IDX_HEADER][15:8];
  wire [1:0]  blockSel  = paramBuf_q[`IDX_HEADER][1:0];
  wire [15:0] setting   = paramBuf_q[`IDX_SETTING];
  wire        isKey     = (cmdCode == `CMD_KEY_VERIFY);
  wire        isUser    = (cmdCode == `CMD_USER_MARGIN);
  wire        isField   = (cmdCode == `CMD_FIELD_MARGIN);
  wire        blockOk   = (blockSel == `BLOCK_PFLASH) || (blockSel == `BLOCK_EEPROM);

  function automatic logic settingOk(input logic [15:0] s, input logic [15:0] maxVal);
    settingOk = (s <= maxVal);
  endfunction

  // key verify faults before compare
  wire keyErr    = (idx_q != `IDX_KEY_LAST)
                 | (backdoorEnableField != `BACKDOOR_ENABLED)
                 | keyLock_q;
  // margin faults
  wire userErr   = (idx_q != `IDX_SETTING) | !userMarginAllowed | !blockOk
                 | !settingOk(setting, `MARGIN_USER_MAX);
  wire fieldErr  = (idx_q != `IDX_SETTING) | !specialMode | !blockOk
                 | !settingOk(setting, `MARGIN_FIELD_MAX);
  wire marginWr  = (state_q == SEQ_DECODE) & ((isUser & !userErr) | (isField & !fieldErr));
  wire launchNow = cmdLaunch & cmd_complete_flag_q;
  wire cmpStart  = (state_q == SEQ_DECODE) & isKey & !keyErr;
  wire cmpDone;
  wire cmpMatch;
  wire decodeErr = (state_q == SEQ_DECODE)
                 & ((isKey & keyErr) | (isUser & userErr) | (isField & fieldErr));
  wire keyFail   = cmpDone & !cmpMatch;

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_keys
      assign keyWords[k] = paramBuf_q[`KEY_FIRST_IDX + 3'(k)];
    end
  endgenerate

  // buffer writes accepted only while idle
  always_ff @(posedge ref_clk) begin
    if (bufWrEn && cmd_complete_flag_q) begin
      paramBuf_q[bufWrIdx] <= bufWrData;
    end
  end

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SEQ_IDLE:   if (launchNow) state_d = SEQ_DECODE;
      SEQ_DECODE: state_d = cmpStart ? SEQ_KEYCMP : SEQ_DONE;
      SEQ_KEYCMP: if (cmpDone) state_d = SEQ_DONE;
      SEQ_DONE:   state_d = SEQ_IDLE;
      default:    state_d = SEQ_IDLE;
    endcase
  end

  // state, index capture and complete flag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= SEQ_IDLE;
      cmd_complete_flag_q  <= 1'b1;
      idx_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      if (launchNow) begin
        cmd_complete_flag_q <= 1'b0;
        idx_q  <= paramIndex;
      end else if (state_q == SEQ_DONE) begin
        cmd_complete_flag_q <= 1'b1;
      end
    end
  end

  // access error: set wins over software clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      access_error_flag_q <= 1'b0;
    end else if (decodeErr || keyFail) begin
      access_error_flag_q <= 1'b1;
    end else if (accessErrClear) begin
      access_error_flag_q <= 1'b0;
    end
  end

  // security state and mismatch lockout; strap caught after release
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      secured_q    <= 1'b1;
      keyLock_q    <= 1'b0;
      strapTaken_q <= 1'b0;
    end else begin
      if (!strapTaken_q) begin
        strapTaken_q <= 1'b1;
        secured_q    <= securedAtReset;
      end else if (cmpDone && cmpMatch) begin
        secured_q <= 1'b0;
      end
      if (keyFail) begin
        keyLock_q <= 1'b1;
      end
    end
  end

  key_compare #(
    .KEY_W (DATA_W)
  ) u_key_compare (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .start       (cmpStart),
    .suppliedKey (keyWords),
    .keyReadAddr (keyReadAddr),
    .keyReadData (keyReadData),
    .cmpDone     (cmpDone),
    .cmpMatch    (cmpMatch)
  );

  margin_select u_margin_select (
    .ref_clk          (ref_clk),
    .rst_n            (rst_n),
    .wrEn             (marginWr),
    .wrEeprom         (blockSel == `BLOCK_EEPROM),
    .wrLevel          (setting[2:0]),
    .pflashReadMargin (pflashReadMargin),
    .eepromReadMargin (eepromReadMargin)
  );

  // outputs; these commands never report through other status bits
  assign cmdCompleteFlag         = cmd_complete_flag_q;
  assign accessErrorFlag         = access_error_flag_q;
  assign secured                 = secured_q;
  assign protectionViolationFlag = 1'b0;
  assign verifyFailHi            = 1'b0;
  assign verifyFailLo            = 1'b0;

endmodule

// ===== bench/flash_key_margin_monitor.sv
/*
  assertion checker for the key verify and margin sequencer.
  assumes it is bound to the sequencer top and sees its ports only.
*/
`timescale 1ns/1ps
module flash_key_margin_monitor
  import flash_key_margin_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              bufWrEn,
  input wire logic [2:0]        bufWrIdx,
  input wire logic [DATA_W-1:0] bufWrData,
  input wire logic [2:0]        paramIndex,
  input wire logic              cmdLaunch,
  input wire logic [1:0]        backdoorEnableField,
  input wire logic              specialMode,
  input wire logic              cmdCompleteFlag,
  input wire logic              accessErrorFlag,
  input wire logic              protectionViolationFlag,
  input wire logic              verifyFailHi,
  input wire logic              verifyFailLo,
  input wire logic              secured,
  input wire margin_level_t     pflashReadMargin,
  input wire margin_level_t     eepromReadMargin
);
  logic [7:0] code_q;
  logic       go;

  // launch qualifier and code of the loaded header word
  assign go = cmdLaunch && cmdCompleteFlag;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) code_q <= 8'h00;
    else if (bufWrEn && bufWrIdx == 3'h0 && cmdCompleteFlag) code_q <= bufWrData[15:8];
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_flag_drops:
    assert property (go |=> !cmdCompleteFlag) else $error("complete flag stayed high");
  chk_flag_returns:
    assert property (go |-> ##[2:10] cmdCompleteFlag) else $error("complete flag never returned");
  chk_backdoor_enable_field_err:
    assert property (go && code_q == 8'h0C && backdoorEnableField != 2'h2 |-> ##[1:4] accessErrorFlag)
      else $error("disabled key access gave no error");
  chk_keyidx_err:
    assert property (go && code_q == 8'h0C && paramIndex != 3'h4 |-> ##[1:4] accessErrorFlag)
      else $error("bad key index gave no error");
  chk_margin_idx:
    assert property (go && code_q inside {8'h0D, 8'h0E} && paramIndex != 3'h1 |-> ##[1:4] accessErrorFlag)
      else $error("bad margin index gave no error");
  chk_field_mode:
    assert property (go && code_q == 8'h0E && !specialMode |-> ##[1:4] accessErrorFlag)
      else $error("field margin outside special mode");
  chk_other_flags:
    assert property (!(protectionViolationFlag || verifyFailHi || verifyFailLo)) else $error("other flag set");
  chk_unsecure_kept:
    assert property (!secured |=> !secured) else $error("security returned without reset");
  chk_pflash_scope:
    assert property ($changed(pflashReadMargin) |-> eepromReadMargin == pflashReadMargin)
      else $error("p-flash level not applied to eeprom");
endmodule

// ===== bench/flash_key_margin_commands_tb.sv
/*
  self-checking bench for the key verify and margin sequencer.
  assumes the design files are compiled first; drives at falling edge.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module flash_key_margin_commands_tb
  import flash_key_margin_pkg::*;
;
  logic ref_clk, rst_n, bufWrEn, cmdLaunch, accessErrClear, specialMode, userMarginAllowed, securedAtReset;
  logic [2:0] bufWrIdx, paramIndex;
  logic [15:0] bufWrData, keyReadData;
  logic [1:0] backdoorEnableField;
  logic [17:0] keyReadAddr;
  logic cmdCompleteFlag, accessErrorFlag, protectionViolationFlag, verifyFailHi, verifyFailLo, secured;
  margin_level_t pflashReadMargin, eepromReadMargin, pe;
  logic [15:0] w [1:4];
  logic [15:0] keyMem [4] = '{16'h1357, 16'h2468, 16'h9ABC, 16'hDEF0};
  int failures = 0;
  int total_checks = 0;

  flash_key_margin_commands DUT (.ref_clk(ref_clk), .rst_n(rst_n), .bufWrEn(bufWrEn), .bufWrIdx(bufWrIdx),
    .bufWrData(bufWrData), .paramIndex(paramIndex), .cmdLaunch(cmdLaunch), .accessErrClear(accessErrClear),
    .backdoorEnableField(backdoorEnableField), .specialMode(specialMode), .userMarginAllowed(userMarginAllowed),
    .securedAtReset(securedAtReset), .keyReadAddr(keyReadAddr), .keyReadData(keyReadData),
    .cmdCompleteFlag(cmdCompleteFlag), .accessErrorFlag(accessErrorFlag),
    .protectionViolationFlag(protectionViolationFlag), .verifyFailHi(verifyFailHi),
    .verifyFailLo(verifyFailLo), .secured(secured), .pflashReadMargin(pflashReadMargin),
    .eepromReadMargin(eepromReadMargin));

  // stored key words, other addresses read a fill pattern
  assign keyReadData = (keyReadAddr[17:2] == 16'hFFC0) ? keyMem[keyReadAddr[1:0]] : 16'hA5A5;

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic rst(input int n);
    @(negedge ref_clk) rst_n = 1'b0;
    repeat (n) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    @(negedge ref_clk);
    bufWrEn = 1'b1;
    bufWrIdx = i;
    bufWrData = d;
    @(negedge ref_clk) bufWrEn = 1'b0;
  endtask

  // load header and words, launch, wait, check error, clear it
  task automatic run(input logic [15:0] h, input logic [2:0] ix, input logic e);
    int n;
    wr(3'h0, h);
    for (int k = 1; k < 5; k++) wr(3'(k), w[k]);
    @(negedge ref_clk);
    paramIndex = ix;
    cmdLaunch = 1'b1;
    @(negedge ref_clk) cmdLaunch = 1'b0;
    `CHK("busy", 1'b0, cmdCompleteFlag)
    n = 0;
    while (cmdCompleteFlag !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (cmdCompleteFlag !== 1'b1) begin
      failures++;
      end_sim;
    end
    `CHK("access_error_flag", e, accessErrorFlag)
    @(negedge ref_clk) accessErrClear = 1'b1;
    @(negedge ref_clk) accessErrClear = 1'b0;
  endtask

  task automatic mchk(input margin_level_t p, input margin_level_t e);
    `CHK("pmargin", p, pflashReadMargin)
    `CHK("emargin", e, eepromReadMargin)
  endtask

  // main sequence
  initial begin
    logic [15:0] eh [4] = '{16'h0D00, 16'h0D00, 16'h0D02, 16'h0E00};
    logic [15:0] es [4] = '{16'h0003, 16'h0001, 16'h0001, 16'h0001};
    logic [2:0] ei [4] = '{3'h1, 3'h0, 3'h1, 3'h1};
    rst_n = 1'b0; bufWrEn = 1'b0; bufWrIdx = 3'h0; bufWrData = 16'h0000; paramIndex = 3'h0;
    cmdLaunch = 1'b0; accessErrClear = 1'b0; backdoorEnableField = 2'h2; specialMode = 1'b0;
    userMarginAllowed = 1'b1; securedAtReset = 1'b1;
    for (int k = 1; k < 5; k++) w[k] = keyMem[k-1];
    rst(20);
    `CHK("secured", 1'b1, secured)
    mchk(3'h0, 3'h0);
    w[1] = 16'h0001; run(16'h0D01, 3'h1, 1'b0); mchk(3'h0, 3'h1);
    w[1] = 16'h0002; run(16'h0D00, 3'h1, 1'b0); mchk(3'h2, 3'h2);
    w[1] = 16'h0000; run(16'h0D00, 3'h1, 1'b0); mchk(3'h0, 3'h0);
    for (int k = 0; k < 4; k++) begin
      w[1] = es[k]; run(eh[k], ei[k], 1'b1); mchk(3'h0, 3'h0);
    end
    userMarginAllowed = 1'b0;
    w[1] = 16'h0001; run(16'h0D00, 3'h1, 1'b1); mchk(3'h0, 3'h0);
    userMarginAllowed = 1'b1;
    specialMode = 1'b1;
    pe = 3'h0;
    for (int s = 1; s < 5; s++) begin
      w[1] = 16'(s); run(16'h0E01, 3'h1, 1'b0); mchk(pe, 3'(s));
      run(16'h0E00, 3'h1, 1'b0); mchk(3'(s), 3'(s));
      pe = 3'(s);
    end
    w[1] = 16'h0005; run(16'h0E00, 3'h1, 1'b1); mchk(3'h4, 3'h4);
    run(16'h0F00, 3'h1, 1'b0); mchk(3'h4, 3'h4);
    w[1] = keyMem[0];
    for (int v = 0; v < 4; v++) if (v != 2) begin
      backdoorEnableField = 2'(v); run(16'h0C00, 3'h4, 1'b1); `CHK("secured", 1'b1, secured)
    end
    backdoorEnableField = 2'h2;
    run(16'h0C00, 3'h3, 1'b1); `CHK("secured", 1'b1, secured)
    run(16'h0C00, 3'h4, 1'b0); `CHK("secured", 1'b0, secured)
    rst(2); `CHK("secured", 1'b1, secured)
    mchk(3'h0, 3'h0);
    w[3] = ~keyMem[2]; run(16'h0C00, 3'h4, 1'b1); `CHK("secured", 1'b1, secured)
    w[3] = keyMem[2]; run(16'h0C00, 3'h4, 1'b1); `CHK("secured", 1'b1, secured)
    rst(2); run(16'h0C00, 3'h4, 1'b0); `CHK("secured", 1'b0, secured)
    securedAtReset = 1'b0;
    rst(2); `CHK("secured", 1'b0, secured)
    securedAtReset = 1'b1;
    rst(2); `CHK("secured", 1'b1, secured)
    end_sim;
  end
endmodule

bind flash_key_margin_commands flash_key_margin_monitor #(.DATA_W(DATA_W)) mon (.ref_clk(ref_clk), .rst_n(rst_n),
  .bufWrEn(bufWrEn), .bufWrIdx(bufWrIdx), .bufWrData(bufWrData), .paramIndex(paramIndex), .cmdLaunch(cmdLaunch),
  .backdoorEnableField(backdoorEnableField), .specialMode(specialMode), .cmdCompleteFlag(cmdCompleteFlag),
  .accessErrorFlag(accessErrorFlag), .protectionViolationFlag(protectionViolationFlag),
  .verifyFailHi(verifyFailHi), .verifyFailLo(verifyFailLo), .secured(secured),
  .pflashReadMargin(pflashReadMargin), .eepromReadMargin(eepromReadMargin));
